/* File: verilog/ahts_sequencer.v */
// Hardware-trigger sequencer for an on-chip converter, with an AXI4-Lite register slave.
// Assumes a synchronous trigger pulse from on-chip logic and a converter core driven
// by the conv_* handshake below; the core returns its data on conv_data_in.
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ahts_consts.vh"

module ahts_sequencer (
  input wire ref_clk,
  input wire rstn,
  input wire hw_trigger,
  input wire [`AHTS_RES_W-1:0] conv_data_in,
  output reg conversion_end_interrupt,
  output wire converter_power,
  output wire [`AHTS_CH_W-1:0] conv_channel,
  output wire conv_busy,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [1:0] ST_STOP = 2'h0;
  localparam [1:0] ST_STANDBY = 2'h1;
  localparam [1:0] ST_TRIG_WAIT = 2'h2;
  localparam [1:0] ST_CONVERT = 2'h3;
  localparam [10:0] CONV_LAST = `AHTS_CONV_CYCLES - 1;

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  reg rst_meta_ff;
  reg rst_sync_ff;
  wire rst_n = rst_sync_ff;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  reg aw_held_ff;
  reg w_held_ff;
  reg [3:0] aw_addr_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;
  reg bvalid_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] bresp_ff;
  reg [1:0] rresp_ff;

  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  wire aw_now = aw_held_ff || (s_axi_awvalid && s_axi_awready);
  wire w_now = w_held_ff || (s_axi_wvalid && s_axi_wready);
  wire [3:0] wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
  wire [31:0] wr_data = w_held_ff ? w_data_ff : s_axi_wdata;
  wire [3:0] wr_strb = w_held_ff ? w_strb_ff : s_axi_wstrb;
  wire wr_fire = aw_now && w_now && !bvalid_ff;

  function addr_mapped;
    input [3:0] addr;
    begin
      addr_mapped = (addr == `AHTS_OFF_MODE) || (addr == `AHTS_OFF_CHSEL) ||
                    (addr == `AHTS_OFF_RESULT) || (addr == `AHTS_OFF_STATUS);
    end
  endfunction

  // Writes act only when the low byte lane is strobed; all fields live there.
  wire wr_low = wr_fire && wr_strb[0] && addr_mapped(wr_addr);
  wire mode_wr = wr_low && (wr_addr == `AHTS_OFF_MODE);
  wire chsel_wr = wr_low && (wr_addr == `AHTS_OFF_CHSEL);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= 4'h0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
    end else begin
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= addr_mapped(wr_addr) ? 2'h0 : 2'h2;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held_ff <= 1'b1;
          aw_addr_ff <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held_ff <= 1'b1;
          w_data_ff <= s_axi_wdata;
          w_strb_ff <= s_axi_wstrb;
        end
        if (bvalid_ff && s_axi_bready) begin
          bvalid_ff <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration and control registers
  // ----------------------------------------------------------------
  reg enable_ff;
  reg start_ff;
  reg wait_mode_ff;
  reg scan_mode_ff;
  reg one_shot_ff;
  reg [`AHTS_CH_W-1:0] chsel_ff;
  reg [`AHTS_RES_W-1:0] result_ff;
  reg [1:0] state_ff;
  reg [1:0] slot_ff;
  reg [10:0] cycle_ff;
  reg [1:0] nxt_state;
  reg [1:0] nxt_slot;
  reg nxt_start;
  reg restart;

  wire [7:0] wb = wr_data[7:0];
  wire wr_enable = wb[`AHTS_MODE_ENABLE_BIT];
  wire wr_start = wb[`AHTS_MODE_START_BIT];
  wire converting = (state_ff == ST_CONVERT);
  wire conv_done = converting && (cycle_ff == CONV_LAST);
  wire last_slot = !scan_mode_ff || (slot_ff == 2'h3);

  // Mode fields are taken only while the unit is disabled; a conversion kept going by a start write with enable clear can still see them move.
  wire cfg_open = !enable_ff;
  wire restart_abort = converting && (hw_trigger || chsel_wr || mode_wr);

  always @* begin
    nxt_state = state_ff;
    nxt_slot = slot_ff;
    nxt_start = start_ff;
    restart = 1'b0;
    if (mode_wr) begin
      nxt_start = wr_start && (wr_enable || enable_ff) && enable_ff;
    end
    case (state_ff)
      ST_STOP: begin
        nxt_start = 1'b0;
        if (mode_wr && wr_enable) begin
          if (wb[`AHTS_MODE_WAIT_BIT]) begin
            nxt_state = ST_TRIG_WAIT;
          end else begin
            nxt_state = ST_STANDBY;
          end
        end
      end
      ST_STANDBY: begin
        if (mode_wr && !wr_enable) begin
          nxt_state = ST_STOP;
        end else if (nxt_start) begin
          nxt_state = ST_TRIG_WAIT;
        end
      end
      ST_TRIG_WAIT: begin
        if (mode_wr && !wr_enable) begin
          nxt_state = ST_STOP;
        end else if (!wait_mode_ff && !nxt_start) begin
          nxt_state = ST_STANDBY;
        end else if (hw_trigger && (wait_mode_ff || start_ff)) begin
          nxt_state = ST_CONVERT;
          nxt_slot = 2'h0;
          nxt_start = 1'b1;
          restart = 1'b1;
        end
      end
      ST_CONVERT: begin
        if (mode_wr && !wr_start) begin
          nxt_start = 1'b0;
          if (wait_mode_ff) begin
            nxt_state = ST_TRIG_WAIT;
          end else begin
            nxt_state = ST_STANDBY;
          end
        end else if (hw_trigger || chsel_wr || mode_wr) begin
          nxt_slot = 2'h0;
          restart = 1'b1;
        end else if (conv_done) begin
          restart = 1'b1;
          if (!last_slot) begin
            nxt_slot = slot_ff + 2'h1;
          end else if (!one_shot_ff) begin
            nxt_slot = 2'h0;
          end else if (wait_mode_ff) begin
            nxt_start = 1'b0;
            nxt_state = ST_STOP;
            restart = 1'b0;
          end else begin
            nxt_state = ST_TRIG_WAIT;
            restart = 1'b0;
          end
        end
      end
      default: begin
        nxt_state = ST_STOP;
      end
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_ff <= 1'b0;
      start_ff <= 1'b0;
      wait_mode_ff <= 1'b0;
      scan_mode_ff <= 1'b0;
      one_shot_ff <= 1'b0;
      chsel_ff <= `AHTS_CHSEL_RESET;
      result_ff <= {`AHTS_RES_W{1'b0}};
      state_ff <= ST_STOP;
      slot_ff <= 2'h0;
      cycle_ff <= 11'h000;
      conversion_end_interrupt <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      slot_ff <= nxt_slot;
      start_ff <= nxt_start;
      if (mode_wr) begin
        enable_ff <= wr_enable;
        if (cfg_open) begin
          wait_mode_ff <= wb[`AHTS_MODE_WAIT_BIT];
          scan_mode_ff <= wb[`AHTS_MODE_SCAN_BIT];
          one_shot_ff <= wb[`AHTS_MODE_ONESHOT_BIT];
        end
      end
      if (chsel_wr) begin
        chsel_ff <= wr_data[`AHTS_CH_W-1:0];
      end
      // Earlier aborts never reach conv_done; an abort on the last cycle is masked by restart_abort, so partial data is dropped.
      conversion_end_interrupt <= conv_done && !restart_abort;
      if (conv_done && !restart_abort) begin
        result_ff <= conv_data_in;
      end
      if (restart || !converting) begin
        cycle_ff <= 11'h000;
      end else begin
        cycle_ff <= cycle_ff + 11'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Converter side and read path
  // ----------------------------------------------------------------
  // In scan mode the select field names the first of four adjacent channels.
  assign conv_channel = scan_mode_ff ? (chsel_ff + {3'h0, slot_ff}) : chsel_ff;
  assign conv_busy = converting;
  // Wait mode powers the converter only while converting; no-wait keeps it up in every state except stop.
  assign converter_power = wait_mode_ff ? converting : (state_ff != ST_STOP);

  function [31:0] read_word;
    input [3:0] addr;
    begin
      case (addr)
        `AHTS_OFF_MODE: read_word = {27'h0, one_shot_ff, scan_mode_ff, wait_mode_ff,
                                     start_ff, enable_ff};
        `AHTS_OFF_CHSEL: read_word = {27'h0, chsel_ff};
        `AHTS_OFF_RESULT: read_word = {22'h0, result_ff};
        `AHTS_OFF_STATUS: read_word = {28'h0, slot_ff, state_ff};
        default: read_word = 32'h0000_0000;
      endcase
    end
  endfunction

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= read_word(s_axi_araddr);
      rresp_ff <= addr_mapped(s_axi_araddr) ? 2'h0 : 2'h2;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule

/* File: common/ahts_consts.vh */
// Constants of the hardware-trigger converter sequencer: register map, fields, timing.
// Assumes a 25 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef AHTS_CONSTS_VH
`define AHTS_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define AHTS_OFF_MODE 4'h0
`define AHTS_OFF_CHSEL 4'h4
`define AHTS_OFF_RESULT 4'h8
`define AHTS_OFF_STATUS 4'hc

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define AHTS_MODE_ENABLE_BIT 0
`define AHTS_MODE_START_BIT 1
`define AHTS_MODE_WAIT_BIT 2
`define AHTS_MODE_SCAN_BIT 3
`define AHTS_MODE_ONESHOT_BIT 4

// ----------------------------------------------------------------
// Channel select and result fields
// ----------------------------------------------------------------
`define AHTS_CH_W 5
`define AHTS_RES_W 10
`define AHTS_CHSEL_RESET 5'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define AHTS_CLK_MHZ 25
`define AHTS_CONV_TIME_NS 1040
`define AHTS_CONV_CYCLES ((`AHTS_CONV_TIME_NS * `AHTS_CLK_MHZ) / 1000)

`endif

/* File: dv/ahts_seq_assertions.sv */
// Port-level checks of the converter sequencer.
// Assumes it is bound onto ahts_sequencer and sees that module's port names.
`timescale 1ns/1ps
module ahts_seq_assertions (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hw_trigger,
  input wire logic conversion_end_interrupt,
  input wire logic converter_power,
  input wire logic conv_busy,
  input wire logic s_axi_awready,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  busy_powered_a: assert property (conv_busy |-> converter_power)
    else $error("conversion running while converter is off");
  start_cause_a: assert property ($rose(conv_busy) |-> $past(hw_trigger))
    else $error("conversion began without a trigger");
  full_conv_a: assert property (conversion_end_interrupt |-> $past(conv_busy, 26))
    else $error("end pulse without a full conversion behind it");
  end_pulse_a: assert property (conversion_end_interrupt |=> !conversion_end_interrupt[*8])
    else $error("end pulse too long or too close");
  trig_abort_a: assert property (hw_trigger && conv_busy |-> ##3 !conversion_end_interrupt[*8])
    else $error("aborted conversion still ended");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while response pending");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  bresp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp != 2'h1)
    else $error("write response uses an exclusive code");
  cover property ($rose(conv_busy));
  cover property (hw_trigger && conv_busy);
  cover property (conversion_end_interrupt && conv_busy);
endmodule

/* File: dv/ahts_core_model.sv */
// Behavioural converter core facing the sequencer's conv_* port.
// Assumes conv_data_in is sampled only while conv_busy is high.
`timescale 1ns/1ps
`include "ahts_consts.vh"
module ahts_core_model (
  input wire logic ref_clk,
  input wire logic conv_busy,
  input wire logic [`AHTS_CH_W-1:0] conv_channel,
  output logic [`AHTS_RES_W-1:0] conv_data_in
);
  // ----------------------------------------------------------------
  // Data answer
  // ----------------------------------------------------------------
  // Outside a conversion the data toggles, so a stray sample never looks valid.
  logic idle_ff = 1'b0;
  always @(posedge ref_clk) idle_ff <= ~idle_ff;
  assign conv_data_in = conv_busy ? {conv_channel, ~conv_channel} : {10{idle_ff}};
endmodule

/* File: dv/test_adc_hw_trigger_sequencer.sv */
// Self-checking bench for the converter sequencer over its register bus.
// Assumes the core model answers each conversion with {channel, ~channel}.
`timescale 1ns/1ps
`include "ahts_consts.vh"
module test_adc_hw_trigger_sequencer;
  logic ref_clk = 0, rstn = 0, trg = 0, awv = 0, wv = 0, arv = 0;
  logic [3:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdv, rdata;
  logic [1:0] bresp, rresp, resp;
  logic irq, pwr, busy, awready, wready, bvalid, arready, rvalid;
  logic [`AHTS_CH_W-1:0] chan;
  logic [`AHTS_RES_W-1:0] cdata;
  int fail_count = 0, comparisons = 0, cyc = 0, n, lat;
  always #20 ref_clk = ~ref_clk;
  // Response ready is held high throughout, which the bus allows.
  ahts_sequencer dut_u (.ref_clk(ref_clk), .rstn(rstn), .hw_trigger(trg), .conv_data_in(cdata),
    .conversion_end_interrupt(irq), .converter_power(pwr), .conv_channel(chan), .conv_busy(busy),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1));
  ahts_core_model core_u (.ref_clk(ref_clk), .conv_busy(busy), .conv_channel(chan),
    .conv_data_in(cdata));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
    end while (!bvalid);
    resp = bresp;
  endtask
  task automatic rd(input logic [3:0] a);
    araddr <= a;
    arv <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arv <= 1'b0;
    end while (!rvalid);
    rdv = rdata;
  endtask
  task automatic trig;
    trg <= 1'b1;
    @(posedge ref_clk);
    trg <= 1'b0;
  endtask
  task automatic wirq(input int lim);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!irq && n < lim);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    logic [4:0] ch;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    wr(4'h2, 32'h1);
    chk("bresp", 2, resp);
    wr(4'h0, 32'h02);
    rd(4'hc);
    chk("state", 0, rdv[1:0]);
    wr(4'h0, 32'h10);
    wr(4'h0, 32'h11);
    rd(4'hc);
    chk("state", 1, rdv[1:0]);
    trig();
    wirq(40);
    chk("idle", 40, n);
    repeat (4) @(posedge ref_clk);
    wr(4'h0, 32'h13);
    rd(4'hc);
    chk("state", 2, rdv[1:0]);
    chk("busy", 0, busy);
    wr(4'h4, 32'h05);
    trig();
    wirq(60);
    lat = n;
    rd(4'h8);
    chk("result", {5'h05, ~5'h05}, rdv);
    rd(4'h0);
    chk("start", 1, rdv[1]);
    wirq(60);
    chk("oneshot", 60, n);
    trig();
    repeat (10) @(posedge ref_clk);
    trig();
    wirq(60);
    chk("restart", lat, n);
    trig();
    repeat (5) @(posedge ref_clk);
    wr(4'h4, 32'h09);
    wirq(60);
    rd(4'h8);
    chk("result", {5'h09, ~5'h09}, rdv);
    // A start rewrite late in a conversion must push the end pulse a full conversion out.
    trig();
    repeat (20) @(posedge ref_clk);
    wr(4'h0, 32'h13);
    wirq(60);
    chk("rewrite", 1, n > 20);
    trig();
    repeat (5) @(posedge ref_clk);
    wr(4'h0, 32'h11);
    wirq(60);
    chk("abort", 60, n);
    chk("power", 1, pwr);
    wr(4'h0, 32'h10);
    rd(4'hc);
    chk("state", 0, rdv[1:0]);
    wr(4'h0, 32'h08);
    wr(4'h0, 32'h09);
    wr(4'h4, 32'h04);
    wr(4'h0, 32'h0b);
    trig();
    for (int i = 0; i < 5; i++) begin
      ch = 5'h04 + 5'(i % 4);
      wirq(60);
      rd(4'h8);
      chk("scan", {ch, ~ch}, rdv);
    end
    wr(4'h0, 32'h09);
    wr(4'h0, 32'h08);
    wr(4'h0, 32'h04);
    trig();
    wirq(40);
    chk("off", 40, n);
    wr(4'h0, 32'h05);
    rd(4'hc);
    chk("state", 2, rdv[1:0]);
    trig();
    wirq(60);
    rd(4'h0);
    chk("start", 1, rdv[1]);
    wirq(60);
    chk("repeat", 1, n <= lat);
    wr(4'h0, 32'h05);
    rd(4'hc);
    chk("state", 2, rdv[1:0]);
    chk("power", 0, pwr);
    final_report();
  end
endmodule
bind ahts_sequencer ahts_seq_assertions chk_u (.ref_clk(ref_clk), .rstn(rstn),
  .hw_trigger(hw_trigger), .conversion_end_interrupt(conversion_end_interrupt),
  .converter_power(converter_power), .conv_busy(conv_busy), .s_axi_awready(s_axi_awready),
  .s_axi_arready(s_axi_arready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp),
  .s_axi_rvalid(s_axi_rvalid));
